/* File: design/lock_and_fuse_access_control.sv */
// Lock-key access gate for the debug port and fuse transfer at start-up
`include "lock_fuse_consts.svh"

module lock_and_fuse_access_control (
   input wire logic clk_sys,
   input wire logic reset_n,
   // Nonvolatile cells, same clock domain, never reset here
   input wire lock_fuse_pkg::fuse_array_t fuse_nv,
   input wire logic [7:0] lock_nv,
   // Debug port request and answer
   input wire logic dbg_req_valid,
   output logic dbg_req_ready,
   input wire lock_fuse_pkg::dbg_req_t dbg_req,
   output logic dbg_resp_valid,
   output logic [7:0] dbg_rdata,
   // System bus toward the memories
   output logic mem_req_valid,
   output lock_fuse_pkg::mem_req_t mem_req,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   // Nonvolatile write and erase commands
   output lock_fuse_pkg::nv_wr_t nv_wr,
   output lock_fuse_pkg::erase_t erase_cmd,
   // Processor view of fuses and write gate
   input wire logic [3:0] cpu_fuse_addr,
   output logic [7:0] cpu_fuse_rdata,
   input wire logic cpu_wr_valid,
   input wire lock_fuse_pkg::space_t cpu_wr_space,
   output logic cpu_wr_grant,
   // Configured peripheral fields and status
   output lock_fuse_pkg::fuse_cfg_t fuse_cfg,
   output logic startup_done,
   output logic device_locked
);

   typedef enum logic [3:0] {
      st_load = 4'b0001,
      st_idle = 4'b0010,
      st_mem = 4'b0100,
      st_resp = 4'b1000
   } state_t;

   state_t state_ff;
   state_t nxt_state;
   logic locked_ff;
   logic done_ff;
   lock_fuse_pkg::fuse_cfg_t cfg_ff;
   lock_fuse_pkg::mem_req_t mem_req_ff;
   lock_fuse_pkg::nv_wr_t nv_wr_ff;
   lock_fuse_pkg::nv_wr_t nxt_nv_wr;
   lock_fuse_pkg::erase_t erase_ff;
   lock_fuse_pkg::erase_t nxt_erase;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic resp_ff;
   logic [7:0] cpu_rdata_ff;
   logic accept;
   logic to_mem;
   logic internal_rd;

   // Fuse byte at an offset; offsets at or past FUSE_COUNT read as ones
   function automatic logic [7:0] fuse_at(
      input lock_fuse_pkg::fuse_array_t arr,
      input logic [3:0] ofs
   );
      logic [7:0] val;
      val = 8'hff;
      if (ofs < 4'(`FUSE_COUNT)) begin
         val = arr[ofs];
      end
      return val;
   endfunction : fuse_at

   // Spaces that sit behind the system bus
   function automatic logic bus_space(input lock_fuse_pkg::space_t sp);
      return (sp == lock_fuse_pkg::space_sram) ||
             (sp == lock_fuse_pkg::space_regs) ||
             (sp == lock_fuse_pkg::space_flash) ||
             (sp == lock_fuse_pkg::space_eeprom) ||
             (sp == lock_fuse_pkg::space_user_row);
   endfunction : bus_space

   // Processor may never write the signature row or any fuse
   function automatic logic cpu_writable(input lock_fuse_pkg::space_t sp);
      return bus_space(sp);
   endfunction : cpu_writable

   assign accept = (state_ff == st_idle) && dbg_req_valid;
   assign dbg_req_ready = (state_ff == st_idle);

   // Debug access that needs the system bus; none of it while locked
   assign to_mem = !locked_ff && bus_space(dbg_req.space) &&
      ((dbg_req.cmd == lock_fuse_pkg::cmd_read) ||
       (dbg_req.cmd == lock_fuse_pkg::cmd_write));

   assign internal_rd = (dbg_req.cmd == lock_fuse_pkg::cmd_read) &&
      !to_mem;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_load: nxt_state = st_idle;
         st_idle: begin
            if (accept) begin
               nxt_state = to_mem ? st_mem : st_resp;
            end
         end
         st_mem: begin
            if (mem_ack) begin
               nxt_state = st_resp;
            end
         end
         st_resp: nxt_state = st_idle;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= st_load;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Lock state: safe value locked until the fuse has been decoded
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         locked_ff <= 1'b1;
      end else if (state_ff == st_load) begin
         locked_ff <= (lock_nv != `LOCK_KEY_OPEN);
      end else if (accept &&
                   dbg_req.cmd == lock_fuse_pkg::cmd_full_erase) begin
         locked_ff <= 1'b0;
      end
   end

   // Fuse copy happens once per reset, so later writes wait for a reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_ff <= '0;
      end else if (state_ff == st_load) begin
         cfg_ff.wd_window <= fuse_nv[`FUSE_OFS_WATCHDOG]
            [`WD_WINDOW_MSB:`WD_WINDOW_LSB];
         cfg_ff.wd_period <= fuse_nv[`FUSE_OFS_WATCHDOG]
            [`WD_PERIOD_MSB:`WD_PERIOD_LSB];
         cfg_ff.bo_level <= fuse_nv[`FUSE_OFS_BROWNOUT]
            [`BO_LEVEL_MSB:`BO_LEVEL_LSB];
         cfg_ff.bo_sample_rate <= fuse_nv[`FUSE_OFS_BROWNOUT]
            [`BO_SAMPLE_BIT];
         cfg_ff.bo_active <= fuse_nv[`FUSE_OFS_BROWNOUT]
            [`BO_ACTIVE_MSB:`BO_ACTIVE_LSB];
         cfg_ff.bo_sleep <= fuse_nv[`FUSE_OFS_BROWNOUT]
            [`BO_SLEEP_MSB:`BO_SLEEP_LSB];
         cfg_ff.oscillator <= fuse_nv[`FUSE_OFS_OSCILLATOR];
         cfg_ff.system_a <= fuse_nv[`FUSE_OFS_SYSTEM_A];
         cfg_ff.system_b <= fuse_nv[`FUSE_OFS_SYSTEM_B];
         cfg_ff.app_end <= fuse_nv[`FUSE_OFS_APP_END];
         cfg_ff.boot_end <= fuse_nv[`FUSE_OFS_BOOT_END];
      end
   end

   // Start-up ends after the single load cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done_ff <= 1'b0;
      end else if (state_ff == st_load) begin
         done_ff <= 1'b1;
      end
   end

   // Read data: internal answers and filler for refused reads
   always_comb begin
      nxt_rdata = `INVALID_DATA;
      if (dbg_req.space == lock_fuse_pkg::space_ctrl_status) begin
         nxt_rdata = 8'h00;
         nxt_rdata[`CS_STATUS_LOCKED_BIT] = locked_ff;
         nxt_rdata[`CS_STATUS_READY_BIT] = done_ff;
      end else if (!locked_ff) begin
         if (dbg_req.space == lock_fuse_pkg::space_fuse) begin
            nxt_rdata = fuse_at(fuse_nv, dbg_req.addr[3:0]);
         end else if (dbg_req.space == lock_fuse_pkg::space_lock) begin
            nxt_rdata = lock_nv;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= 8'h00;
      end else if (accept && internal_rd) begin
         rdata_ff <= nxt_rdata;
      end else if (state_ff == st_mem && mem_ack) begin
         rdata_ff <= mem_rdata;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resp_ff <= 1'b0;
      end else begin
         resp_ff <= (nxt_state == st_resp) && (state_ff != st_resp);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_req_ff <= '0;
      end else if (accept && to_mem) begin
         mem_req_ff.write <= (dbg_req.cmd == lock_fuse_pkg::cmd_write);
         mem_req_ff.space <= dbg_req.space;
         mem_req_ff.addr <= dbg_req.addr;
         mem_req_ff.wdata <= dbg_req.wdata;
      end
   end

   // Nonvolatile writes and erase; fuses keep their own content otherwise
   always_comb begin
      nxt_nv_wr = '0;
      nxt_erase = '0;
      if (accept) begin
         unique case (dbg_req.cmd)
            lock_fuse_pkg::cmd_fuse_write: begin
               // User row stays writable even when locked
               if (dbg_req.space == lock_fuse_pkg::space_user_row ||
                   (!locked_ff &&
                    (dbg_req.space == lock_fuse_pkg::space_fuse ||
                     dbg_req.space == lock_fuse_pkg::space_lock))) begin
                  nxt_nv_wr.valid = 1'b1;
                  nxt_nv_wr.space = dbg_req.space;
                  nxt_nv_wr.addr = dbg_req.addr[7:0];
                  nxt_nv_wr.data = dbg_req.wdata;
               end
            end
            lock_fuse_pkg::cmd_full_erase: begin
               nxt_erase.flash = 1'b1;
               nxt_erase.eeprom = locked_ff ||
                  !fuse_nv[`FUSE_OFS_SYSTEM_A][`SYSA_KEEP_EEPROM_BIT];
               // Erase reopens the part; user row is not touched
               nxt_nv_wr.valid = 1'b1;
               nxt_nv_wr.space = lock_fuse_pkg::space_lock;
               nxt_nv_wr.addr = 8'(`LOCK_OFS);
               nxt_nv_wr.data = `LOCK_KEY_OPEN;
            end
            default: begin
               nxt_nv_wr = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         nv_wr_ff <= '0;
      end else begin
         nv_wr_ff <= nxt_nv_wr;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         erase_ff <= '0;
      end else begin
         erase_ff <= nxt_erase;
      end
   end

   // Processor path is never gated by the lock
   // Registered so the processor sees a settled byte, one cycle late
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cpu_rdata_ff <= 8'h00;
      end else if (cpu_fuse_addr == `LOCK_OFS + 4'(`FUSE_COUNT)) begin
         cpu_rdata_ff <= lock_nv;
      end else begin
         cpu_rdata_ff <= fuse_at(fuse_nv, cpu_fuse_addr);
      end
   end

   assign cpu_fuse_rdata = cpu_rdata_ff;
   assign cpu_wr_grant = cpu_wr_valid && cpu_writable(cpu_wr_space);

   assign mem_req_valid = (state_ff == st_mem);
   assign mem_req = mem_req_ff;
   assign nv_wr = nv_wr_ff;
   assign erase_cmd = erase_ff;
   assign dbg_resp_valid = resp_ff;
   assign dbg_rdata = rdata_ff;
   assign fuse_cfg = cfg_ff;
   assign startup_done = done_ff;
   assign device_locked = locked_ff;

endmodule : lock_and_fuse_access_control

/* File: shared/lock_fuse_consts.svh */
// Offsets, field positions, key values and codes of the lock and fuse block
`ifndef LOCK_FUSE_CONSTS_SVH
`define LOCK_FUSE_CONSTS_SVH
`define LOCK_KEY_OPEN 8'hc5
`define LOCK_OFS 4'h0
`define FUSE_COUNT 9
`define FUSE_OFS_WATCHDOG 4'h0
`define FUSE_OFS_BROWNOUT 4'h1
`define FUSE_OFS_OSCILLATOR 4'h2
`define FUSE_OFS_SYSTEM_A 4'h5
`define FUSE_OFS_SYSTEM_B 4'h6
`define FUSE_OFS_APP_END 4'h7
`define FUSE_OFS_BOOT_END 4'h8
`define WD_WINDOW_MSB 7
`define WD_WINDOW_LSB 4
`define WD_PERIOD_MSB 3
`define WD_PERIOD_LSB 0
`define BO_LEVEL_MSB 7
`define BO_LEVEL_LSB 5
`define BO_SAMPLE_BIT 4
`define BO_ACTIVE_MSB 3
`define BO_ACTIVE_LSB 2
`define BO_SLEEP_MSB 1
`define BO_SLEEP_LSB 0
`define SYSA_KEEP_EEPROM_BIT 0
`define INVALID_DATA 8'hff
`define CS_STATUS_LOCKED_BIT 0
`define CS_STATUS_READY_BIT 1
`endif

/* File: shared/lock_fuse_pkg.sv */
// Types shared by the lock and fuse access control block
`include "lock_fuse_consts.svh"
package lock_fuse_pkg;
   typedef enum logic [3:0] {
      space_sram = 4'h0,
      space_regs = 4'h1,
      space_flash = 4'h2,
      space_eeprom = 4'h3,
      space_user_row = 4'h4,
      space_sig_row = 4'h5,
      space_fuse = 4'h6,
      space_lock = 4'h7,
      space_ctrl_status = 4'h8
   } space_t;
   typedef enum logic [1:0] {
      cmd_read = 2'h0,
      cmd_write = 2'h1,
      cmd_fuse_write = 2'h2,
      cmd_full_erase = 2'h3
   } dbg_cmd_t;
   typedef struct packed {
      dbg_cmd_t cmd;
      space_t space;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dbg_req_t;
   typedef struct packed {
      logic write;
      space_t space;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_t;
   typedef struct packed {
      logic valid;
      space_t space;
      logic [7:0] addr;
      logic [7:0] data;
   } nv_wr_t;
   typedef struct packed {
      logic flash;
      logic eeprom;
   } erase_t;
   typedef struct packed {
      logic [3:0] wd_window;
      logic [3:0] wd_period;
      logic [2:0] bo_level;
      logic bo_sample_rate;
      logic [1:0] bo_active;
      logic [1:0] bo_sleep;
      logic [7:0] oscillator;
      logic [7:0] system_a;
      logic [7:0] system_b;
      logic [7:0] app_end;
      logic [7:0] boot_end;
   } fuse_cfg_t;
   typedef logic [`FUSE_COUNT-1:0][7:0] fuse_array_t;
endpackage : lock_fuse_pkg

/* File: tb/dbg_host_model.sv */
// Behavioural debug host issuing one request at a time
module dbg_host_model (
   input wire logic clk_sys,
   input wire logic dbg_req_ready,
   input wire logic dbg_resp_valid,
   input wire logic [7:0] dbg_rdata,
   output logic dbg_req_valid,
   output lock_fuse_pkg::dbg_req_t dbg_req
);
   timeunit 1ns;
   timeprecision 1ps;
   int stalls = 0;
   initial begin
      dbg_req_valid = 1'b0;
      dbg_req = '0;
   end
   // Fields scrambled once taken, so a stale request never looks valid
   task automatic xfer(input lock_fuse_pkg::dbg_cmd_t c,
      input lock_fuse_pkg::space_t s, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      dbg_req_valid <= 1'b1;
      dbg_req <= '{c, s, a, d};
      @(posedge clk_sys);
      while (dbg_req_ready !== 1'b1 && n < 40) begin
         n++;
         @(posedge clk_sys);
      end
      if (dbg_req_ready !== 1'b1) stalls++;
      dbg_req_valid <= 1'b0;
      dbg_req <= lock_fuse_pkg::dbg_req_t'(~dbg_req);
      n = 0;
      @(posedge clk_sys);
      while (dbg_resp_valid !== 1'b1 && n < 40) begin
         n++;
         @(posedge clk_sys);
      end
      if (dbg_resp_valid !== 1'b1) stalls++;
      q = dbg_rdata;
      @(posedge clk_sys);
   endtask : xfer
endmodule : dbg_host_model

/* File: tb/lock_fuse_monitor.sv */
// Port checker of the lock gate and fuse transfer
`include "lock_fuse_consts.svh"
module lock_fuse_monitor (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire lock_fuse_pkg::fuse_array_t fuse_nv,
   input wire logic [7:0] lock_nv,
   input wire logic dbg_req_valid,
   input wire logic dbg_req_ready,
   input wire lock_fuse_pkg::dbg_req_t dbg_req,
   input wire logic dbg_resp_valid,
   input wire logic [7:0] dbg_rdata,
   input wire logic mem_req_valid,
   input wire lock_fuse_pkg::nv_wr_t nv_wr,
   input wire lock_fuse_pkg::erase_t erase_cmd,
   input wire logic cpu_wr_valid,
   input wire lock_fuse_pkg::space_t cpu_wr_space,
   input wire logic cpu_wr_grant,
   input wire lock_fuse_pkg::fuse_cfg_t fuse_cfg,
   input wire logic startup_done,
   input wire logic device_locked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_lock_decode: assert property (
      $rose(startup_done) |-> device_locked == (lock_nv != `LOCK_KEY_OPEN))
      else $error("lock state disagrees with lock fuse");
   // Erase is the only legal mid-session change of the lock state
   chk_lock_held: assert property (
      startup_done && $past(startup_done) && !erase_cmd.flash
      |-> $stable(device_locked)) else $error("lock state changed");
   chk_locked_read: assert property (
      dbg_req_valid && dbg_req_ready && device_locked
      && dbg_req.cmd == lock_fuse_pkg::cmd_read
      && dbg_req.space != lock_fuse_pkg::space_ctrl_status
      |=> dbg_resp_valid && dbg_rdata == `INVALID_DATA)
      else $error("locked read not invalid");
   chk_no_bus: assert property (
      device_locked |-> !mem_req_valid) else $error("bus used while locked");
   chk_fuse_gate: assert property (
      nv_wr.valid && !erase_cmd.flash && nv_wr.space inside
      {lock_fuse_pkg::space_fuse, lock_fuse_pkg::space_lock}
      |-> !$past(device_locked)) else $error("fuse written while locked");
   chk_erase_only: assert property (
      $past(startup_done) && $fell(device_locked) |-> erase_cmd.flash)
      else $error("unlocked without erase");
   chk_erase_eeprom: assert property (
      erase_cmd.flash && $past(device_locked) |-> erase_cmd.eeprom)
      else $error("locked erase kept eeprom");
   chk_cfg_load: assert property (
      $rose(startup_done) |-> fuse_cfg == {fuse_nv[0], fuse_nv[1],
      fuse_nv[2], fuse_nv[5], fuse_nv[6], fuse_nv[7], fuse_nv[8]})
      else $error("fuse fields not loaded");
   chk_cfg_held: assert property (
      $past(startup_done) |-> $stable(fuse_cfg))
      else $error("fuse fields changed in session");
   chk_cpu_gate: assert property (
      cpu_wr_valid |-> cpu_wr_grant == (cpu_wr_space inside
      {[lock_fuse_pkg::space_sram:lock_fuse_pkg::space_user_row]}))
      else $error("processor write gate wrong");
endmodule : lock_fuse_monitor
bind lock_and_fuse_access_control lock_fuse_monitor mon (
   .clk_sys(clk_sys), .reset_n(reset_n), .fuse_nv(fuse_nv),
   .lock_nv(lock_nv), .dbg_req_valid(dbg_req_valid),
   .dbg_req_ready(dbg_req_ready), .dbg_req(dbg_req),
   .dbg_resp_valid(dbg_resp_valid), .dbg_rdata(dbg_rdata),
   .mem_req_valid(mem_req_valid), .nv_wr(nv_wr), .erase_cmd(erase_cmd),
   .cpu_wr_valid(cpu_wr_valid), .cpu_wr_space(cpu_wr_space),
   .cpu_wr_grant(cpu_wr_grant), .fuse_cfg(fuse_cfg),
   .startup_done(startup_done), .device_locked(device_locked)
);

/* File: tb/tb.sv */
// Self-checking bench of the lock gate and fuse transfer
`include "lock_fuse_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   lock_fuse_pkg::fuse_array_t fuse_nv = '0;
   logic [7:0] lock_nv = 8'hc5;
   logic [7:0] mem_rdata = 8'h00;
   logic mem_ack = 1'b0;
   logic [3:0] cpu_fuse_addr = 4'h0;
   logic cpu_wr_valid = 1'b0;
   lock_fuse_pkg::space_t cpu_wr_space = lock_fuse_pkg::space_sram;
   logic dbg_req_valid, dbg_req_ready, dbg_resp_valid, mem_req_valid;
   logic startup_done, device_locked, cpu_wr_grant;
   logic [7:0] dbg_rdata, cpu_fuse_rdata, r;
   lock_fuse_pkg::dbg_req_t dbg_req;
   lock_fuse_pkg::mem_req_t mem_req;
   lock_fuse_pkg::nv_wr_t nv_wr, last_nv;
   lock_fuse_pkg::erase_t erase_cmd, last_er;
   lock_fuse_pkg::fuse_cfg_t fuse_cfg;
   int miscompares = 0;
   int cmp_count = 0;
   int nv_cnt = 0;
   int base;
   logic [7:0] last_wr = 8'h00;
   lock_and_fuse_access_control DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .fuse_nv(fuse_nv),
      .lock_nv(lock_nv), .dbg_req_valid(dbg_req_valid),
      .dbg_req_ready(dbg_req_ready), .dbg_req(dbg_req),
      .dbg_resp_valid(dbg_resp_valid), .dbg_rdata(dbg_rdata),
      .mem_req_valid(mem_req_valid), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .nv_wr(nv_wr),
      .erase_cmd(erase_cmd), .cpu_fuse_addr(cpu_fuse_addr),
      .cpu_fuse_rdata(cpu_fuse_rdata), .cpu_wr_valid(cpu_wr_valid),
      .cpu_wr_space(cpu_wr_space), .cpu_wr_grant(cpu_wr_grant),
      .fuse_cfg(fuse_cfg), .startup_done(startup_done),
      .device_locked(device_locked)
   );
   dbg_host_model host (
      .clk_sys(clk_sys), .dbg_req_ready(dbg_req_ready),
      .dbg_resp_valid(dbg_resp_valid), .dbg_rdata(dbg_rdata),
      .dbg_req_valid(dbg_req_valid), .dbg_req(dbg_req)
   );
   always #10 clk_sys = ~clk_sys;
   // Memory acks one cycle late; idle data inverted so it never matches
   always @(posedge clk_sys) begin
      mem_ack <= mem_req_valid && !mem_ack;
      if (mem_req_valid && !mem_ack) mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;
      else mem_rdata <= ~mem_rdata;
      if (nv_wr.valid === 1'b1) nv_cnt <= nv_cnt + 1;
      if (nv_wr.valid === 1'b1) last_nv <= nv_wr;
      if (erase_cmd.flash === 1'b1) last_er <= erase_cmd;
      if (mem_req_valid === 1'b1 && mem_req.write === 1'b1)
         last_wr <= mem_req.wdata;
   end
   task automatic cmp8(input string n, input logic [7:0] e,
      input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : cmp8
   task automatic rst(input logic [7:0] lk);
      reset_n <= 1'b0;
      lock_nv <= lk;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask : rst
   task automatic cpu_rd(input logic [3:0] a);
      cpu_fuse_addr <= a;
      repeat (2) @(posedge clk_sys);
      r = cpu_fuse_rdata;
   endtask : cpu_rd
   task automatic dx(input logic [1:0] c, input logic [3:0] s,
      input logic [15:0] a, input logic [7:0] d);
      host.xfer(lock_fuse_pkg::dbg_cmd_t'(c), lock_fuse_pkg::space_t'(s),
         a, d, r);
   endtask : dx
   task automatic print_verdict;
      miscompares += host.stalls;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end
   // Codes: read 0, write 1, fuse write 2, erase 3; spaces per package
   initial begin
      fuse_nv[0] <= 8'h3a;
      fuse_nv[1] <= 8'hb6;
      fuse_nv[5] <= 8'hf7;
      rst(`LOCK_KEY_OPEN);
      cmp8("locked", 8'h00, {7'h0, device_locked});
      cmp8("wd window", 8'h03, {4'h0, fuse_cfg.wd_window});
      cmp8("wd period", 8'h0a, {4'h0, fuse_cfg.wd_period});
      cmp8("bo fields", 8'hb6, fuse_cfg[47:40]);
      dx(2'h0, 4'h6, 16'h0001, 8'h00);
      cmp8("dbg fuse read", 8'hb6, r);
      cpu_rd(4'h9);
      cmp8("cpu lock read", `LOCK_KEY_OPEN, r);
      dx(2'h0, 4'h0, 16'h0034, 8'h00);
      cmp8("bus read", 8'h6e, r);
      dx(2'h1, 4'h0, 16'h0040, 8'ha5);
      cmp8("bus write", 8'ha5, last_wr);
      dx(2'h2, 4'h6, 16'h0002, 8'h7e);
      cmp8("fuse writes", 8'h01, 8'(nv_cnt));
      fuse_nv[0] <= 8'hc1;
      repeat (2) @(posedge clk_sys);
      cmp8("wd window held", 8'h03, {4'h0, fuse_cfg.wd_window});
      for (int s = 0; s < 9; s++) begin
         cpu_wr_valid <= 1'b1;
         cpu_wr_space <= lock_fuse_pkg::space_t'(s);
         @(posedge clk_sys);
         cmp8("grant", {7'h0, s < 5}, {7'h0, cpu_wr_grant});
      end
      cpu_wr_valid <= 1'b0;
      dx(2'h3, 4'h2, 16'h0000, 8'h00);
      cmp8("erase eeprom", 8'h00, {7'h0, last_er.eeprom});
      rst(8'hc4);
      cmp8("locked", 8'h01, {7'h0, device_locked});
      cmp8("wd window", 8'h0c, {4'h0, fuse_cfg.wd_window});
      for (int s = 0; s < 8; s++) begin
         dx(2'h0, 4'(s), 16'h0010, 8'h00);
         cmp8("locked read", `INVALID_DATA, r);
      end
      dx(2'h0, 4'h8, 16'h0000, 8'h00);
      cmp8("status read", 8'h03, r);
      base = nv_cnt;
      dx(2'h2, 4'h4, 16'h0003, 8'h12);
      cmp8("user row data", 8'h12, last_nv.data);
      dx(2'h2, 4'h7, 16'h0000, `LOCK_KEY_OPEN);
      dx(2'h1, 4'h0, 16'h0034, 8'h55);
      cmp8("locked bus write", 8'ha5, last_wr);
      cmp8("locked nv writes", 8'h01, 8'(nv_cnt - base));
      cpu_rd(4'h1);
      cmp8("cpu fuse read", 8'hb6, r);
      dx(2'h3, 4'h2, 16'h0000, 8'h00);
      cmp8("erase eeprom", 8'h01, {7'h0, last_er.eeprom});
      cmp8("unlocked", 8'h00, {7'h0, device_locked});
      cmp8("erase target", 8'h07, {4'h0, last_nv.space});
      cmp8("erase key", `LOCK_KEY_OPEN, last_nv.data);
      dx(2'h0, 4'h0, 16'h0021, 8'h00);
      cmp8("bus read", 8'h7b, r);
      print_verdict();
   end
endmodule : tb
